// ### src/ltp_top.sv
`timescale 1ns/1ps
`include "ltp_params.svh"
module ltp_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // trap event from command path
  input wire logic illegal_access,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // phy controls and interrupt
  output logic strobe_gating_select,
  output logic rx_power_down,
  output logic [2:0] read_latency,
  output logic irq
);
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ltp_bus_t;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `LTP_RAW_STATUS_OFF) || (a == `LTP_MASKED_STATUS_OFF) ||
              (a == `LTP_ENABLE_SET_OFF) || (a == `LTP_ENABLE_CLEAR_OFF) ||
              (a == `LTP_PHY_CTRL_OFF);
  endfunction : addr_ok

  logic rst_n;
  ltp_bus_t b_q;
  ltp_bus_t b_d;
  ltp_pkg::ltp_core_t st;
  logic do_wr;
  logic wr_raw;
  logic wr_masked;
  logic wr_set;
  logic wr_clear;
  logic wr_phy;
  logic [31:0] rd_word;

  ltp_reset_sync u_rst (
    .clock(clock),
    .reset_n(reset_n),
    .sync_reset_n(rst_n)
  );

  ltp_core u_core (
    .clock(clock),
    .rst_n(rst_n),
    .illegal_access(illegal_access),
    .wr_raw(wr_raw),
    .wr_masked(wr_masked),
    .wr_set(wr_set),
    .wr_clear(wr_clear),
    .wr_phy(wr_phy),
    .wdata(b_q.wdata),
    .state(st)
  );

  // write commits once both halves held and no response pending
  assign do_wr = b_q.aw_held && b_q.w_held && !b_q.bvalid;
  // only the lane holding bit 2 / bits 7..0 matters
  assign wr_raw = do_wr && b_q.wstrb[0] && (b_q.awaddr == `LTP_RAW_STATUS_OFF);
  assign wr_masked = do_wr && b_q.wstrb[0] && (b_q.awaddr == `LTP_MASKED_STATUS_OFF);
  assign wr_set = do_wr && b_q.wstrb[0] && (b_q.awaddr == `LTP_ENABLE_SET_OFF);
  assign wr_clear = do_wr && b_q.wstrb[0] && (b_q.awaddr == `LTP_ENABLE_CLEAR_OFF);
  assign wr_phy = do_wr && b_q.wstrb[0] && (b_q.awaddr == `LTP_PHY_CTRL_OFF);

  always_comb begin
    rd_word = `LTP_RESET_VALUE;
    if (s_axi_araddr == `LTP_RAW_STATUS_OFF) begin
      rd_word[`LTP_TRAP_BIT] = st.raw_trap_flag;
    end else if (s_axi_araddr == `LTP_MASKED_STATUS_OFF) begin
      rd_word[`LTP_TRAP_BIT] = st.masked_trap_flag;
    end else if (s_axi_araddr == `LTP_ENABLE_SET_OFF) begin
      rd_word[`LTP_TRAP_BIT] = st.trap_enable;
    end else if (s_axi_araddr == `LTP_ENABLE_CLEAR_OFF) begin
      rd_word[`LTP_TRAP_BIT] = st.trap_enable;
    end else if (s_axi_araddr == `LTP_PHY_CTRL_OFF) begin
      rd_word[`LTP_STROBE_SEL_BIT] = st.strobe_gating_select;
      rd_word[`LTP_PWRDN_BIT] = st.rx_power_down;
      rd_word[`LTP_LAT_LSB +: `LTP_LAT_W] = st.read_latency;
    end
  end

  always_comb begin
    b_d = b_q;
    if (s_axi_awvalid && !b_q.aw_held) begin
      b_d.aw_held = 1'b1;
      b_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !b_q.w_held) begin
      b_d.w_held = 1'b1;
      b_d.wdata = s_axi_wdata;
      b_d.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      b_d.bvalid = 1'b1;
      b_d.bresp = addr_ok(b_q.awaddr) ? `LTP_AXI_OKAY : `LTP_AXI_SLVERR;
    end
    if (b_q.bvalid && s_axi_bready) begin
      b_d.bvalid = 1'b0;
      b_d.aw_held = 1'b0;
      b_d.w_held = 1'b0;
    end
    if (s_axi_arvalid && !b_q.rvalid) begin
      b_d.rvalid = 1'b1;
      b_d.rdata = rd_word;
      b_d.rresp = addr_ok(s_axi_araddr) ? `LTP_AXI_OKAY : `LTP_AXI_SLVERR;
    end else if (b_q.rvalid && s_axi_rready) begin
      b_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign s_axi_awready = !b_q.aw_held;
  assign s_axi_wready = !b_q.w_held;
  assign s_axi_bvalid = b_q.bvalid;
  assign s_axi_bresp = b_q.bresp;
  assign s_axi_arready = !b_q.rvalid;
  assign s_axi_rvalid = b_q.rvalid;
  assign s_axi_rdata = b_q.rdata;
  assign s_axi_rresp = b_q.rresp;
  assign strobe_gating_select = st.strobe_gating_select;
  assign rx_power_down = st.rx_power_down;
  assign read_latency = st.read_latency;
  assign irq = st.irq;
endmodule : ltp_top

// ### src/ltp_params.svh
`ifndef LTP_PARAMS_SVH
`define LTP_PARAMS_SVH
`define LTP_RAW_STATUS_OFF 8'h00
`define LTP_MASKED_STATUS_OFF 8'h04
`define LTP_ENABLE_SET_OFF 8'h08
`define LTP_ENABLE_CLEAR_OFF 8'h0c
`define LTP_PHY_CTRL_OFF 8'h10
`define LTP_TRAP_BIT 2
`define LTP_STROBE_SEL_BIT 7
`define LTP_PWRDN_BIT 6
`define LTP_LAT_LSB 0
`define LTP_LAT_W 3
`define LTP_RESET_VALUE 32'h0000_0000
`define LTP_AXI_OKAY 2'h0
`define LTP_AXI_SLVERR 2'h2
`endif

// ### src/ltp_pkg.sv
package ltp_pkg;
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_MATCH,
    SEL_BAD
  } ltp_sel_t;
  typedef struct packed {
    logic raw_trap_flag;
    logic masked_trap_flag;
    logic trap_enable;
    logic strobe_gating_select;
    logic rx_power_down;
    logic [2:0] read_latency;
    logic irq;
  } ltp_core_t;
endpackage : ltp_pkg

// ### src/ltp_reset_sync.sv
`timescale 1ns/1ps
module ltp_reset_sync (
  // clock and raw reset
  input wire logic clock,
  input wire logic reset_n,
  // released reset
  output logic sync_reset_n
);
  typedef struct packed {
    logic first;
    logic second;
  } ltp_rs_t;
  ltp_rs_t s_q;
  ltp_rs_t s_d;
  always_comb begin
    s_d.first = 1'b1;
    s_d.second = s_q.first;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_reset_n = s_q.second;
endmodule : ltp_reset_sync

// ### src/ltp_core.sv
`timescale 1ns/1ps
`include "ltp_params.svh"
module ltp_core (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // trap event
  input wire logic illegal_access,
  // decoded write strobes, data
  input wire logic wr_raw,
  input wire logic wr_masked,
  input wire logic wr_set,
  input wire logic wr_clear,
  input wire logic wr_phy,
  input wire logic [31:0] wdata,
  // state
  output ltp_pkg::ltp_core_t state
);
  ltp_pkg::ltp_core_t c_q;
  ltp_pkg::ltp_core_t c_d;
  logic trap_clr;
  logic en_set;
  logic en_clr;
  always_comb begin
    c_d = c_q;
    trap_clr = (wr_raw | wr_masked) & wdata[`LTP_TRAP_BIT];
    en_set = wr_set & wdata[`LTP_TRAP_BIT];
    en_clr = wr_clear & wdata[`LTP_TRAP_BIT];
    // both written together: disabled
    if (en_set && en_clr) begin
      c_d.trap_enable = 1'b0;
    end else if (en_set) begin
      c_d.trap_enable = 1'b1;
    end else if (en_clr) begin
      c_d.trap_enable = 1'b0;
    end
    // event wins over clear
    if (illegal_access) begin
      c_d.raw_trap_flag = 1'b1;
    end else if (trap_clr) begin
      c_d.raw_trap_flag = 1'b0;
    end
    if (illegal_access && c_q.trap_enable) begin
      c_d.masked_trap_flag = 1'b1;
    end else if (trap_clr) begin
      c_d.masked_trap_flag = 1'b0;
    end
    if (wr_phy) begin
      c_d.strobe_gating_select = wdata[`LTP_STROBE_SEL_BIT];
      c_d.rx_power_down = wdata[`LTP_PWRDN_BIT];
      c_d.read_latency = wdata[`LTP_LAT_LSB +: `LTP_LAT_W];
    end
    c_d.irq = c_d.masked_trap_flag;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end
  assign state = c_q;
endmodule : ltp_core

// ### tb/ltp_checker.sv
`timescale 1ns/1ps
module ltp_checker (
  // top ports
  input wire logic clock,
  input wire logic reset_n,
  input wire logic illegal_access,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic strobe_gating_select,
  input wire logic [2:0] read_latency,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_irq_from_trap: assert property ($rose(irq) |-> $past(illegal_access)) else $error("irq no trap");
  a_irq_by_write: assert property ($fell(irq) |-> $rose(s_axi_bvalid)) else $error("irq fell");
  a_lat_by_write: assert property (!$stable(read_latency) |-> $rose(s_axi_bvalid)) else $error("lat moved");
  a_sel_by_write: assert property (!$stable(strobe_gating_select) |-> $rose(s_axi_bvalid)) else $error("sel moved");
  a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw ready");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("r moved");
  c_irq: cover property ($rose(irq));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_b_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : ltp_checker
bind ltp_top ltp_checker ltp_checker_i (.*);

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic illegal_access = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, strobe_gating_select, rx_power_down;
  logic irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [2:0] read_latency;
  integer n_errors = 0, n_checks = 0, seed = 21, i, k, w;
  logic done;
  // assumed cas latency of the attached memory
  localparam int cas = 3;
  ltp_top ltp_top_i (.*);
  initial forever #20 clock = ~clock;
  function logic [31:0] phy_exp(input logic [31:0] x);
    return x & 32'hc7;
  endfunction : phy_exp
  task stop_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // bounded wait for the response, ready raised after a random delay
  task wr(input logic [7:0] a, input logic [31:0] x);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    w = $random(seed) & 3;
    done = 1'h0;
    for (k = 0; k < 40 && !done; k++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'h0;
        r = s_axi_bresp;
        done = 1'h1;
      end else if (k >= w) s_axi_bready <= 1'h1;
    end
    if (!done) begin
      n_errors++;
      stop_test();
    end
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    w = $random(seed) & 3;
    done = 1'h0;
    for (k = 0; k < 40 && !done; k++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'h0;
        v = s_axi_rdata;
        r = s_axi_rresp;
        done = 1'h1;
      end else if (k >= w) s_axi_rready <= 1'h1;
    end
    if (!done) begin
      n_errors++;
      stop_test();
    end
  endtask : rd
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk("rdata", e, v);
  endtask : rc
  task trap;
    illegal_access <= 1'h1;
    @(posedge clock);
    illegal_access <= 1'h0;
    @(posedge clock);
  endtask : trap
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    for (i = 0; i < 5; i++) rc(8'(i * 4), 32'h0);
    trap();
    rc(8'h0, 32'h4);
    rc(8'h4, 32'h0);
    wr(8'h4, 32'h0);
    rc(8'h0, 32'h4);
    wr(8'h4, 32'h4);
    rc(8'h0, 32'h0);
    wr(8'h8, 32'h0);
    rc(8'hc, 32'h0);
    s_axi_wstrb <= 4'h0;
    wr(8'h8, 32'h4);
    rc(8'h8, 32'h0);
    s_axi_wstrb <= 4'hf;
    wr(8'h8, 32'h4);
    rc(8'hc, 32'h4);
    trap();
    rc(8'h4, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    wr(8'hc, 32'h4);
    rc(8'h8, 32'h0);
    chk("irq", 32'h1, 32'(irq));
    wr(8'h0, 32'h4);
    rc(8'h4, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    trap();
    rc(8'h4, 32'h0);
    // event during a clear: the set wins
    illegal_access <= 1'h1;
    wr(8'h0, 32'h4);
    illegal_access <= 1'h0;
    rc(8'h0, 32'h4);
    for (i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'h85 : ($random(seed) & 32'hc0) | 32'(cas + 1 + ($random(seed) & 1));
      wr(8'h10, d);
      rc(8'h10, phy_exp(d));
      chk("sel", 32'(d[7]), 32'(strobe_gating_select));
      chk("lat", 32'(d[2:0]), 32'(read_latency));
      chk("pwrdn", 32'(d[6]), 32'(rx_power_down));
    end
    // reset in mid-run clears flags and phy fields
    reset_n <= 1'h0;
    repeat (2) @(posedge clock);
    reset_n <= 1'h1;
    repeat (3) @(posedge clock);
    chk("lat", 32'h0, 32'(read_latency));
    chk("irq", 32'h0, 32'(irq));
    rc(8'h0, 32'h0);
    rc(8'h10, 32'h0);
    wr(8'h14, 32'h4);
    chk("bresp", 32'h2, 32'(r));
    rc(8'h14, 32'h0);
    chk("rresp", 32'h2, 32'(r));
    stop_test();
  end
endmodule : tb_top
